//--- design/tvrf_accum.v
// Sixteen-sample averager with combined three-current difference input
`timescale 1ns/1ps
`include "tvrf_regs.vh"
module tvrf_accum (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Control
  input wire clear_i,
  input wire avg_off_i,
  // Samples
  input wire sample_valid_i,
  input wire [10:0] sample_i,
  // Result
  output reg done_o,
  output reg [10:0] mean_o
);
  reg [14:0] sum;
  reg [4:0] count;
  wire [14:0] next_sum;
  wire [4:0] next_count;

  assign next_sum = sum + {4'h0, sample_i};
  assign next_count = count + 5'h01;

  // Sixteen samples summed, divided by shifting
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sum <= 15'h0000;
      count <= 5'h00;
      done_o <= 1'b0;
      mean_o <= 11'h000;
    end else begin
      done_o <= 1'b0;
      if (clear_i) begin
        sum <= 15'h0000;
        count <= 5'h00;
      end else if (sample_valid_i) begin
        if (avg_off_i) begin
          mean_o <= sample_i;
          done_o <= 1'b1;
        end else if (next_count == `TVRF_AVG_COUNT) begin
          mean_o <= next_sum[14:4];
          done_o <= 1'b1;
          sum <= 15'h0000;
          count <= 5'h00;
        end else begin
          sum <= next_sum;
          count <= next_count;
        end
      end
    end
  end
endmodule

//--- design/tvrf_regs.vh
// Register offsets, field positions, codes, averaging count and limits for the result formatter
`ifndef TVRF_REGS_VH
`define TVRF_REGS_VH
`define TVRF_OFS_LOCAL_TEMP 8'h26
`define TVRF_OFS_CHAN_SEL 8'h55
`define TVRF_OFS_FRACTION 8'h77
`define TVRF_OFS_CHIPSET_SUPPLY_INPUT 8'h21
`define TVRF_OFS_VCC 8'h22
`define TVRF_OFS_REMOTE1 8'h25
`define TVRF_OFS_REMOTE2 8'h27
`define TVRF_OFS_CONFIG2 8'h73
`define TVRF_CFG_AVG_OFF 4
`define TVRF_CFG_SINGLE 6
`define TVRF_SEL_HI 7
`define TVRF_SEL_LO 5
`define TVRF_CH_CHIPSET 3'h1
`define TVRF_CH_SUPPLY 3'h2
`define TVRF_CH_REMOTE1 3'h5
`define TVRF_CH_LOCAL 3'h6
`define TVRF_CH_REMOTE2 3'h7
`define TVRF_FR_R2_HI 7
`define TVRF_FR_LOC_HI 5
`define TVRF_FR_R1_HI 3
`define TVRF_AVG_COUNT 5'h10
`define TVRF_CODE_MAX 10'h3FF
`define TVRF_OFFSET64 8'h40
`define TVRF_TC_FAULT 8'h80
`define TVRF_EXT_FAULT 8'h00
`define TVRF_TC_MIN 8'hC1
`define TVRF_TC_MAX 8'h7F
`define TVRF_EXT_MIN 8'h01
`define TVRF_EXT_MAX 8'hFF
`endif

//--- design/tvrf_top.v
// Measurement sequencer, result formatting and result registers of the monitor
// How it works
// - In single-channel mode the channel comes from bits 7:5 of the 0x55 register.
// - Codes 001 chipset, 010 supply, 101 remote1, 110 local, 111 remote2.
// - Voltage results are unsigned 10-bit codes saturating at 0 and 1023.
// - Nominal supply or chipset input reads code 768, three quarters scale.
// - Local temperature upper eight bits go to the 0x26 register.
// - Range -63..127 twos complement or -63..191 offset-64, quarter-degree steps.
// - Twos complement: zero is zero, negatives twos complement, fault reads -128.
// - Extended format stores temperature plus 64; all-zero byte flags diode fault.
// - Remote results are 10 bits; two low bits live in the fraction register.
// - Fraction register: remote2 bits 7:6, local 5:4, remote1 3:2.
// - Each remote result is the mean of sixteen measurement cycles.
// - Current steps I to N1*I, then I to N2*I; differences are combined.
// - Two remote diode channels plus the local sensor are measured.
`timescale 1ns/1ps
`include "tvrf_regs.vh"
module tvrf_top (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  // Format select: high for offset-64 extended range
  input wire ext_range_i,
  // Converter interface
  output reg [2:0] adc_chan_o,
  output reg [1:0] diode_current_o,
  output reg adc_start_o,
  input wire adc_done_i,
  input wire [10:0] adc_data_i,
  input wire [1:0] diode_fault_i,
  // Completion pulse
  output reg result_update_o
);
  // ----------------------------------------
  // State encoding
  // ----------------------------------------
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_BASE1 = 5'h02;
  localparam [4:0] ST_HIGH1 = 5'h04;
  localparam [4:0] ST_BASE2 = 5'h08;
  localparam [4:0] ST_HIGH2 = 5'h10;
  localparam [1:0] CUR_BASE = 2'h0;
  localparam [1:0] CUR_N1 = 2'h1;
  localparam [1:0] CUR_N2 = 2'h2;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] chan_sel;
  reg [7:0] config2;
  reg [9:0] chipset_supply_input_code;
  reg [9:0] vcc_code;
  reg [7:0] remote1_val;
  reg [7:0] local_val;
  reg [7:0] remote2_val;
  reg [7:0] fraction;
  reg [4:0] state;
  reg [2:0] chan;
  reg [10:0] base_sample;
  reg [10:0] delta_sum;
  reg avg_valid;
  reg [10:0] avg_sample;
  reg [1:0] fault_sync1;
  reg [1:0] fault_sync2;
  wire avg_done;
  wire [10:0] avg_mean;
  wire single_mode;
  wire is_remote;
  wire [7:0] temp_byte;
  wire fault_now;
  wire cfg_write;
  reg [2:0] next_chan;

  assign single_mode = config2[`TVRF_CFG_SINGLE];
  // A mode change restarts the average so stale samples never mix in
  assign cfg_write = reg_wr_i && (reg_addr_i == `TVRF_OFS_CONFIG2);
  assign is_remote = (chan == `TVRF_CH_REMOTE1) || (chan == `TVRF_CH_REMOTE2);

  // ----------------------------------------
  // Register writes and reads
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_sel <= 8'h00;
      config2 <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `TVRF_OFS_CHAN_SEL) begin
        chan_sel <= reg_wdata_i;
      end else if (reg_addr_i == `TVRF_OFS_CONFIG2) begin
        config2 <= reg_wdata_i;
      end
    end
  end

  always @* begin
    if (reg_addr_i == `TVRF_OFS_LOCAL_TEMP) begin
      reg_rdata_o = local_val;
    end else if (reg_addr_i == `TVRF_OFS_REMOTE1) begin
      reg_rdata_o = remote1_val;
    end else if (reg_addr_i == `TVRF_OFS_REMOTE2) begin
      reg_rdata_o = remote2_val;
    end else if (reg_addr_i == `TVRF_OFS_FRACTION) begin
      reg_rdata_o = fraction;
    end else if (reg_addr_i == `TVRF_OFS_CHAN_SEL) begin
      reg_rdata_o = chan_sel;
    end else if (reg_addr_i == `TVRF_OFS_CONFIG2) begin
      reg_rdata_o = config2;
    end else if (reg_addr_i == `TVRF_OFS_CHIPSET_SUPPLY_INPUT) begin
      reg_rdata_o = chipset_supply_input_code[9:2];
    end else if (reg_addr_i == `TVRF_OFS_VCC) begin
      reg_rdata_o = vcc_code[9:2];
    end else begin
      reg_rdata_o = 8'h00;
    end
  end

  // ----------------------------------------
  // Channel rotation
  // ----------------------------------------
  always @* begin
    if (single_mode) begin
      next_chan = chan_sel[`TVRF_SEL_HI:`TVRF_SEL_LO];
    end else begin
      case (chan)
        `TVRF_CH_CHIPSET: next_chan = `TVRF_CH_SUPPLY;
        `TVRF_CH_SUPPLY: next_chan = `TVRF_CH_REMOTE1;
        `TVRF_CH_REMOTE1: next_chan = `TVRF_CH_LOCAL;
        `TVRF_CH_LOCAL: next_chan = `TVRF_CH_REMOTE2;
        default: next_chan = `TVRF_CH_CHIPSET;
      endcase
    end
  end

  // Fault lines come from the analog side
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_sync1 <= 2'h0;
      fault_sync2 <= 2'h0;
    end else begin
      fault_sync1 <= diode_fault_i;
      fault_sync2 <= fault_sync1;
    end
  end

  // ----------------------------------------
  // Measurement sequencer
  // ----------------------------------------
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      chan <= `TVRF_CH_CHIPSET;
      adc_chan_o <= `TVRF_CH_CHIPSET;
      diode_current_o <= CUR_BASE;
      adc_start_o <= 1'b0;
      base_sample <= 11'h000;
      delta_sum <= 11'h000;
      avg_valid <= 1'b0;
      avg_sample <= 11'h000;
    end else begin
      adc_start_o <= 1'b0;
      avg_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Wait until the last result is stored and the channel has moved on
          if (!avg_valid && !avg_done) begin
            adc_chan_o <= chan;
            diode_current_o <= CUR_BASE;
            adc_start_o <= 1'b1;
            state <= is_remote ? ST_BASE1 : ST_HIGH2;
          end
        end
        ST_BASE1: begin
          if (adc_done_i) begin
            base_sample <= adc_data_i;
            diode_current_o <= CUR_N1;
            adc_start_o <= 1'b1;
            state <= ST_HIGH1;
          end
        end
        ST_HIGH1: begin
          if (adc_done_i) begin
            delta_sum <= adc_data_i - base_sample;
            diode_current_o <= CUR_BASE;
            adc_start_o <= 1'b1;
            state <= ST_BASE2;
          end
        end
        ST_BASE2: begin
          if (adc_done_i) begin
            base_sample <= adc_data_i;
            diode_current_o <= CUR_N2;
            adc_start_o <= 1'b1;
            state <= ST_HIGH2;
          end
        end
        default: begin
          if (adc_done_i) begin
            avg_valid <= 1'b1;
            avg_sample <= is_remote ? (delta_sum + adc_data_i - base_sample) : adc_data_i;
            diode_current_o <= CUR_BASE;
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  tvrf_accum u_accum (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clear_i(cfg_write),
    .avg_off_i(config2[`TVRF_CFG_AVG_OFF]),
    .sample_valid_i(avg_valid),
    .sample_i(avg_sample),
    .done_o(avg_done),
    .mean_o(avg_mean)
  );

  // ----------------------------------------
  // Result formatting
  // ----------------------------------------
  // Mean is offset-64 temperature in quarter degrees, top bit is overflow
  assign fault_now = (chan == `TVRF_CH_REMOTE1) ? fault_sync2[0] :
                     (chan == `TVRF_CH_REMOTE2) ? fault_sync2[1] : 1'b0;
  assign temp_byte = fault_now ? (ext_range_i ? `TVRF_EXT_FAULT : `TVRF_TC_FAULT) :
                     ext_range_i ? (avg_mean[10] ? `TVRF_EXT_MAX :
                     (avg_mean[9:2] < `TVRF_EXT_MIN) ? `TVRF_EXT_MIN : avg_mean[9:2]) :
                     (avg_mean[10] || avg_mean[9:2] > (`TVRF_TC_MAX + `TVRF_OFFSET64)) ?
                     `TVRF_TC_MAX :
                     (avg_mean[9:2] < `TVRF_EXT_MIN) ? `TVRF_TC_MIN :
                     (avg_mean[9:2] - `TVRF_OFFSET64);

  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chipset_supply_input_code <= 10'h000;
      vcc_code <= 10'h000;
      remote1_val <= 8'h00;
      local_val <= 8'h00;
      remote2_val <= 8'h00;
      fraction <= 8'h00;
      result_update_o <= 1'b0;
    end else begin
      result_update_o <= avg_done;
      if (avg_done) begin
        case (chan)
          `TVRF_CH_CHIPSET: chipset_supply_input_code <= avg_mean[10] ? `TVRF_CODE_MAX : avg_mean[9:0];
          `TVRF_CH_SUPPLY: vcc_code <= avg_mean[10] ? `TVRF_CODE_MAX : avg_mean[9:0];
          `TVRF_CH_REMOTE1: begin
            remote1_val <= temp_byte;
            fraction[`TVRF_FR_R1_HI -: 2] <= fault_now ? 2'h0 : avg_mean[1:0];
          end
          `TVRF_CH_LOCAL: begin
            local_val <= temp_byte;
            fraction[`TVRF_FR_LOC_HI -: 2] <= avg_mean[1:0];
          end
          `TVRF_CH_REMOTE2: begin
            remote2_val <= temp_byte;
            fraction[`TVRF_FR_R2_HI -: 2] <= fault_now ? 2'h0 : avg_mean[1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Channel advances once the averaged result is stored
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan <= `TVRF_CH_CHIPSET;
    end else if (avg_done) begin
      chan <= next_chan;
    end
  end
endmodule

//--- test/tb_tvrf_top.sv
// Register-level regression of the result formatter
`timescale 1ns/1ps
module tb_tvrf_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] reg_addr = 8'h00;
  reg reg_wr = 1'b0;
  reg [7:0] reg_wdata = 8'h00;
  reg ext_range = 1'b0;
  reg [1:0] diode_fault = 2'b00;
  reg slow = 1'b0;
  reg wobble = 1'b0;
  reg [87:0] level = 88'h0;
  wire [7:0] reg_rdata;
  wire [2:0] adc_chan;
  wire [1:0] diode_current;
  wire adc_start;
  wire adc_done;
  wire [10:0] adc_data;
  wire result_update;
  integer fails = 0;
  integer tests_run = 0;
  integer cycles = 0;
  integer start_cnt = 0;
  integer starts_seen = 0;
  always #12.5 sys_clk = ~sys_clk;
  tvrf_top tvrf_top_i (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .ext_range_i(ext_range), .adc_chan_o(adc_chan), .diode_current_o(diode_current),
    .adc_start_o(adc_start), .adc_done_i(adc_done), .adc_data_i(adc_data),
    .diode_fault_i(diode_fault), .result_update_o(result_update));
  tvrf_diode_model tvrf_diode_model_i (.sys_clk_i(sys_clk), .rst_i(rst),
    .adc_start_i(adc_start), .adc_chan_i(adc_chan), .diode_current_i(diode_current),
    .slow_i(slow), .wobble_i(wobble), .level_i(level), .adc_done_o(adc_done),
    .adc_data_o(adc_data));
  // -----------------------------
  // Start counting and timeout
  // -----------------------------
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (result_update === 1'b1) begin
      starts_seen <= start_cnt;
      start_cnt <= 0;
    end else if (adc_start === 1'b1)
      start_cnt <= start_cnt + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      #2;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #2;
      reg_wr = 1'b0;
    end
  endtask
  task chk(input [7:0] a, input [7:0] x);
    begin
      @(posedge sys_clk);
      #2;
      reg_addr = a;
      #1;
      tests_run = tests_run + 1;
      if (reg_rdata !== x) begin
        fails = fails + 1;
        $display("MISMATCH %0t reg %h read %h want %h", $time, a, reg_rdata, x);
      end
    end
  endtask
  task chkc(input integer x);
    begin
      tests_run = tests_run + 1;
      if (starts_seen !== x) begin
        fails = fails + 1;
        $display("MISMATCH %0t starts %0d want %0d", $time, starts_seen, x);
      end
    end
  endtask
  task wait_upd;
    integer k;
    integer n;
    begin
      for (n = 0; n < 2; n = n + 1) begin
        k = 0;
        do begin
          @(posedge sys_clk);
          #1;
          k = k + 1;
        end while (result_update !== 1'b1 && k < 3000);
        if (k >= 3000) begin
          fails = fails + 1;
          $display("MISMATCH %0t no result update", $time);
        end
      end
      #1;
    end
  endtask
  task meas(input [2:0] ch, input [10:0] v, input [1:0] f, input e, input [7:0] a,
    input [7:0] x);
    begin
      @(posedge sys_clk);
      #2;
      level[ch*11 +: 11] = v;
      diode_fault = f;
      ext_range = e;
      wr(8'h55, {ch, 5'h00});
      reg_addr = a;
      wait_upd;
      chk(a, x);
    end
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    chk(8'h55, 8'h00);
    chk(8'h77, 8'h00);
    wr(8'h00, 8'h5A);
    chk(8'h00, 8'h00);
    wr(8'h73, 8'h50);
    wr(8'h55, 8'hA0);
    chk(8'h55, 8'hA0);
    $display("test registers done");
    meas(3'h1, 11'h300, 2'b00, 1'b0, 8'h21, 8'hC0);
    meas(3'h2, 11'h400, 2'b00, 1'b0, 8'h22, 8'hFF);
    meas(3'h2, 11'h000, 2'b00, 1'b0, 8'h22, 8'h00);
    meas(3'h6, 11'h166, 2'b00, 1'b0, 8'h26, 8'h19);
    meas(3'h5, 11'h1CB, 2'b00, 1'b0, 8'h25, 8'h32);
    meas(3'h7, 11'h0D8, 2'b00, 1'b0, 8'h27, 8'hF6);
    wr(8'h77, 8'hFF);
    chk(8'h77, 8'h2C);
    meas(3'h7, 11'h0D8, 2'b00, 1'b1, 8'h27, 8'h36);
    meas(3'h6, 11'h100, 2'b00, 1'b0, 8'h26, 8'h00);
    meas(3'h6, 11'h100, 2'b00, 1'b1, 8'h26, 8'h40);
    meas(3'h6, 11'h358, 2'b00, 1'b0, 8'h26, 8'h7F);
    meas(3'h6, 11'h3FC, 2'b00, 1'b1, 8'h26, 8'hFF);
    meas(3'h6, 11'h002, 2'b00, 1'b1, 8'h26, 8'h01);
    meas(3'h6, 11'h004, 2'b00, 1'b0, 8'h26, 8'hC1);
    meas(3'h7, 11'h0D8, 2'b10, 1'b0, 8'h27, 8'h80);
    meas(3'h7, 11'h0D8, 2'b10, 1'b1, 8'h27, 8'h00);
    chk(8'h77, 8'h0C);
    meas(3'h5, 11'h1CB, 2'b01, 1'b0, 8'h25, 8'h80);
    chk(8'h77, 8'h00);
    $display("test formats done");
    wr(8'h73, 8'h40);
    slow = 1'b1;
    wobble = 1'b1;
    meas(3'h5, 11'h1CB, 2'b00, 1'b0, 8'h25, 8'h33);
    chk(8'h77, 8'h04);
    chkc(64);
    wr(8'h73, 8'h50);
    wobble = 1'b0;
    meas(3'h5, 11'h1CB, 2'b00, 1'b0, 8'h25, 8'h32);
    chkc(4);
    $display("test averaging done");
    report_and_stop;
  end
endmodule

//--- test/tvrf_diode_model.sv
// Converter and remote diode model answering conversion starts
`timescale 1ns/1ps
module tvrf_diode_model (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Requests
  input wire adc_start_i,
  input wire [2:0] adc_chan_i,
  input wire [1:0] diode_current_i,
  input wire slow_i,
  input wire wobble_i,
  input wire [87:0] level_i,
  // Answer
  output reg adc_done_o,
  output reg [10:0] adc_data_o
);
  reg [3:0] left;
  reg [10:0] held;
  reg phase;
  wire [10:0] lvl = level_i[adc_chan_i*11 +: 11];
  wire remote = adc_chan_i[2] & adc_chan_i[0];
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      left <= 4'h0;
      held <= 11'h000;
      phase <= 1'b0;
      adc_done_o <= 1'b0;
      adc_data_o <= 11'h000;
    end else begin
      adc_done_o <= (left == 4'h1);
      // Data line shows the inverse value outside the answer cycle
      adc_data_o <= (left == 4'h1) ? held : ~held;
      if (left != 4'h0)
        left <= left - 4'h1;
      if (adc_start_i) begin
        left <= slow_i ? 4'h8 : 4'h2;
        if (!remote)
          held <= lvl;
        else if (diode_current_i == 2'h0)
          held <= 11'h020;
        else if (diode_current_i == 2'h1)
          held <= 11'h020 + (lvl >> 1) + {8'h00, wobble_i & phase, 2'b00};
        else begin
          held <= 11'h020 + lvl - (lvl >> 1);
          phase <= ~phase;
        end
      end
    end
  end
endmodule

//--- test/tvrf_monitor.sv
// Port checks for the result formatter
`timescale 1ns/1ps
module tvrf_monitor (
  // Clock and reset
  input wire sys_clk_i,
  input wire rst_i,
  // Register port
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  // Converter side
  input wire ext_range_i,
  input wire [2:0] adc_chan_o,
  input wire [1:0] diode_current_o,
  input wire adc_start_o,
  input wire adc_done_i,
  input wire result_update_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire remote = (adc_chan_o == 3'h5) || (adc_chan_o == 3'h7);
  AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o)
    else $error("start longer than one cycle");
  AST_UPDATE_PULSE: assert property (result_update_o |=> !result_update_o)
    else $error("update longer than one cycle");
  AST_CURRENT_REMOTE: assert property (diode_current_o != 2'h0 |-> remote)
    else $error("diode current on a non-remote channel");
  AST_CURRENT_ORDER: assert property ($changed(diode_current_o)
    && diode_current_o != 2'h0 |-> $past(diode_current_o) == 2'h0)
    else $error("multiple current not entered from base current");
  AST_PHASE_NEXT: assert property (adc_done_i && remote
    && diode_current_o != 2'h2 |-> ##[1:2] adc_start_o)
    else $error("next current step not started");
  AST_FRAC_LOW: assert property (reg_addr_i == 8'h77 |-> reg_rdata_o[1:0] == 2'b00)
    else $error("fraction low bits not zero");
  AST_SEL_READBACK: assert property ((reg_wr_i && reg_addr_i == 8'h55) ##1
    (reg_addr_i == 8'h55) |-> reg_rdata_o == $past(reg_wdata_i))
    else $error("channel select not read back");
  AST_STORE_TOGETHER: assert property ((reg_addr_i inside {8'h25, 8'h26, 8'h27})
    && $stable(reg_addr_i) && $stable(ext_range_i) && $changed(reg_rdata_o)
    |-> ##[0:1] result_update_o)
    else $error("result changed without update");
  AST_UNMAPPED: assert property (reg_addr_i == 8'h00 |-> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tvrf_top tvrf_monitor tvrf_monitor_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .ext_range_i(ext_range_i), .adc_chan_o(adc_chan_o),
  .diode_current_o(diode_current_o), .adc_start_o(adc_start_o),
  .adc_done_i(adc_done_i), .result_update_o(result_update_o));
